// ---- design/drs_map.vh ----
// Purpose: constants for the display hardware reset sequencer
// Assumes: core clock of 125 MHz (8 ns period)
// Notes:   times are kept in their own unit; cycle counts derive from them
`ifndef DRS_MAP_VH
`define DRS_MAP_VH
`define DRS_CLK_MHZ          125
`define DRS_REJECT_US        5
`define DRS_ACCEPT_US        9
`define DRS_MIN_PULSE_US     10
`define DRS_LOAD_START_MS    5
`define DRS_REL_SLEEP_MS     5
`define DRS_REL_AWAKE_MS     120
`define DRS_BLANK_MS         120
// every time is a whole multiple of the clock period, so these counts are exact
`define DRS_REJECT_CYC       (`DRS_REJECT_US * `DRS_CLK_MHZ)
`define DRS_ACCEPT_CYC       (`DRS_ACCEPT_US * `DRS_CLK_MHZ)
`define DRS_GLITCH_CYC       (`DRS_REJECT_US * `DRS_CLK_MHZ)
`define DRS_REL_SLEEP_CYC    (`DRS_REL_SLEEP_MS * 1000 * `DRS_CLK_MHZ)
`define DRS_REL_AWAKE_CYC    (`DRS_REL_AWAKE_MS * 1000 * `DRS_CLK_MHZ)
`define DRS_BLANK_CYC        (`DRS_BLANK_MS * 1000 * `DRS_CLK_MHZ)
// pin sync lag comes off the release limit; slack lets the load fit after the blank
`define DRS_SYNC_LAG         4
`define DRS_LOAD_SLACK       8
// non-volatile image layout
`define DRS_NV_WORDS         16
`define DRS_NV_AW            4
`define DRS_NV_DW            8
`define DRS_NV_ID0           4'h0
`define DRS_NV_ID1           4'h1
`define DRS_NV_ID2           4'h2
`define DRS_NV_CEL           4'h3
`endif

// ---- design/drs_nv_store.v ----
// Purpose: small non-volatile settings image, read through a register
// Assumes: contents fixed at build time by parameters
// Notes:   one-cycle read latency
`timescale 1ns/1ns
module drs_nv_store #(
  parameter AW   = 4,
  parameter DW   = 8,
  parameter [7:0] ID0  = 8'h5A, // arbitrary value
  parameter [7:0] ID1  = 8'h3C, // arbitrary value
  parameter [7:0] ID2  = 8'h01, // arbitrary value
  parameter [7:0] CEL  = 8'h20
)(
  input  wire          core_clk,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  // constant image, other words carry plain defaults
  function [DW-1:0] img;
    input [AW-1:0] a;
    begin
      case (a)
        0:       img = ID0[DW-1:0];
        1:       img = ID1[DW-1:0];
        2:       img = ID2[DW-1:0];
        3:       img = CEL[DW-1:0];
        default: img = {{(DW-AW){1'b0}}, a};
      endcase
    end
  endfunction

  // registered read data
  always @(posedge core_clk)
  begin
    rd_data <= img(rd_addr);
  end
endmodule // drs_nv_store

// ---- design/drs_reset_seq.v ----
// Summary of operation
// - ignore reset pulses under 5 us, full reset beyond 9 us; host holds 10 us.
// - glitch filter stays active during a valid reset pulse.
// - release loads id bytes, electrode level and settings from storage; the code loads only the id bytes and electrode level.
// - settings load repeats every release, starting within 5 ms of rising edge; after an awake reset the load waits for the blank to end.
// - release from low-power state completes within 5 ms.
// - release from awake state completes within 120 ms.
// - reset while awake runs a blanking sequence of at most 120 ms.
// - reset while in low-power state keeps display blank throughout.
// - afterwards all state returns to hardware-reset defaults.
//
// Purpose: hardware reset filter and release sequencer of a display controller
// Assumes: hw_reset_line_n is asynchronous; sleep_state comes from core logic
// Notes:   a threshold between 5 and 9 us is used (reject_cyc parameter)
`timescale 1ns/1ns
`include "drs_map.vh"
module drs_reset_seq #(
  parameter integer REJECT_CYC  = `DRS_REJECT_CYC,
  parameter integer GLITCH_CYC  = `DRS_GLITCH_CYC,
  parameter integer SLEEP_CYC   = `DRS_REL_SLEEP_CYC,
  parameter integer AWAKE_CYC   = `DRS_REL_AWAKE_CYC,
  parameter integer BLANK_CYC   = `DRS_BLANK_CYC,
  parameter integer CW          = 24
)(
  input  wire                  core_clk,
  input  wire                  rst,
  input  wire                  hw_reset_line_n,
  input  wire                  sleep_state,
  output reg                   core_reset,
  output reg                   display_blank,
  output reg                   release_busy,
  output reg                   load_busy,
  output reg  [7:0]            id_byte0,
  output reg  [7:0]            id_byte1,
  output reg  [7:0]            id_byte2,
  output reg  [7:0]            common_electrode_level,
  output reg                   sleep_default
);
  localparam [5:0] S_RUN   = 6'b00_0001;
  localparam [5:0] S_QUAL  = 6'b00_0010;
  localparam [5:0] S_BLANK = 6'b00_0100;
  localparam [5:0] S_HELD  = 6'b00_1000;
  localparam [5:0] S_LOAD  = 6'b01_0000;
  localparam [5:0] S_WAIT  = 6'b10_0000;

  // end points of the counted spans; release is timed from the pin edge,
  // so the sync lag is taken off, and the blank ends early enough that
  // the storage load still fits inside the awake limit
  localparam integer SLEEP_END = SLEEP_CYC - `DRS_SYNC_LAG;
  localparam integer AWAKE_END = AWAKE_CYC - `DRS_SYNC_LAG;
  localparam integer BLANK_END = BLANK_CYC - `DRS_LOAD_SLACK;

  reg [1:0]               sync_pipe;
  reg [5:0]               state;
  reg [CW-1:0]            low_cnt;
  reg [CW-1:0]            high_cnt;
  reg [CW-1:0]            rel_cnt;
  reg [CW-1:0]            blank_cnt;
  reg                     was_awake;
  reg [`DRS_NV_AW-1:0]    nv_addr;
  reg [`DRS_NV_AW-1:0]    nv_addr_q;
  reg                     nv_valid;
  wire [`DRS_NV_DW-1:0]   nv_data;
  wire                    line_low;

  // saturating increment, shared by all counters
  function [CW-1:0] inc_sat;
    input [CW-1:0] v;
    begin
      inc_sat = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // two flops before any logic reads the pin
  always @(posedge core_clk)
  begin
    if (rst)
      sync_pipe <= 2'b11;
    else
      sync_pipe <= {sync_pipe[0], hw_reset_line_n};
  end
  assign line_low = ~sync_pipe[1];

  drs_nv_store #(
    .AW (`DRS_NV_AW),
    .DW (`DRS_NV_DW)
  ) u_nv (
    .core_clk (core_clk),
    .rd_addr  (nv_addr),
    .rd_data  (nv_data)
  );

  // main sequencer
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state         <= S_RUN;
      low_cnt       <= {CW{1'b0}};
      high_cnt      <= {CW{1'b0}};
      rel_cnt       <= {CW{1'b0}};
      blank_cnt     <= {CW{1'b0}};
      was_awake     <= 1'b0;
      nv_addr       <= {`DRS_NV_AW{1'b0}};
      nv_addr_q     <= {`DRS_NV_AW{1'b0}};
      nv_valid      <= 1'b0;
      core_reset    <= 1'b0;
      display_blank <= 1'b0;
      release_busy  <= 1'b0;
      load_busy     <= 1'b0;
      id_byte0      <= 8'h00;
      id_byte1      <= 8'h00;
      id_byte2      <= 8'h00;
      common_electrode_level <= 8'h00;
      sleep_default <= 1'b1;
    end
    else
    begin
      case (state)
        S_RUN:
        begin
          low_cnt <= {CW{1'b0}};
          // outside reset the mode follows the core; reset forces low power
          sleep_default <= sleep_state;
          if (line_low)
            state <= S_QUAL;
        end
        S_QUAL:
        begin
          if (!line_low)
            state <= S_RUN;
          else if (low_cnt >= REJECT_CYC[CW-1:0])
          begin
            // awake reset blanks; sleep stays blank
            core_reset    <= 1'b1;
            display_blank <= 1'b1;
            release_busy  <= 1'b1;
            was_awake     <= ~sleep_state;
            blank_cnt     <= {CW{1'b0}};
            high_cnt      <= {CW{1'b0}};
            rel_cnt       <= {CW{1'b0}};
            state         <= sleep_state ? S_HELD : S_BLANK;
          end
          low_cnt <= inc_sat(low_cnt);
        end
        S_BLANK:
        begin
          blank_cnt <= inc_sat(blank_cnt);
          // release time runs from the pin edge, even while blanking
          if (line_low)
          begin
            high_cnt <= {CW{1'b0}};
            rel_cnt  <= {CW{1'b0}};
          end
          else
          begin
            high_cnt <= inc_sat(high_cnt);
            rel_cnt  <= inc_sat(rel_cnt);
          end
          if (blank_cnt >= BLANK_END[CW-1:0])
            state <= S_HELD;
        end
        S_HELD:
        begin
          // short highs inside a valid pulse are ignored
          if (line_low)
          begin
            high_cnt <= {CW{1'b0}};
            rel_cnt  <= {CW{1'b0}};
          end
          else
          begin
            high_cnt <= inc_sat(high_cnt);
            rel_cnt  <= inc_sat(rel_cnt);
          end
          if (!line_low && high_cnt >= GLITCH_CYC[CW-1:0])
          begin
            // load begins once the pin has stayed high GLITCH_CYC cycles; rel_cnt keeps counting
            nv_addr   <= `DRS_NV_ID0;
            nv_valid  <= 1'b0;
            load_busy <= 1'b1;
            state     <= S_LOAD;
          end
        end
        S_LOAD:
        begin
          // copy id bytes and electrode level
          rel_cnt   <= inc_sat(rel_cnt);
          nv_addr_q <= nv_addr;
          nv_valid  <= 1'b1;
          if (nv_addr != `DRS_NV_CEL)
            nv_addr <= nv_addr + {{(`DRS_NV_AW-1){1'b0}}, 1'b1};
          if (nv_valid)
          begin
            case (nv_addr_q)
              `DRS_NV_ID0: id_byte0 <= nv_data;
              `DRS_NV_ID1: id_byte1 <= nv_data;
              `DRS_NV_ID2: id_byte2 <= nv_data;
              `DRS_NV_CEL: common_electrode_level <= nv_data;
              default:     id_byte0 <= id_byte0;
            endcase
            if (nv_addr_q == `DRS_NV_CEL)
            begin
              load_busy <= 1'b0;
              state     <= S_WAIT;
            end
          end
          // a new low pulse restarts the held phase; costs a reload
          if (line_low)
          begin
            high_cnt  <= {CW{1'b0}};
            rel_cnt   <= {CW{1'b0}};
            load_busy <= 1'b0;
            state     <= S_HELD;
          end
        end
        S_WAIT:
        begin
          // sleep release within 5 ms; awake within 120 ms
          rel_cnt <= inc_sat(rel_cnt);
          if (line_low)
          begin
            high_cnt <= {CW{1'b0}};
            rel_cnt  <= {CW{1'b0}};
            state    <= S_HELD;
          end
          else if (rel_cnt >= (was_awake ? AWAKE_END[CW-1:0] : SLEEP_END[CW-1:0]))
          begin
            core_reset    <= 1'b0;
            display_blank <= 1'b0;
            release_busy  <= 1'b0;
            sleep_default <= 1'b1;
            state         <= S_RUN;
          end
        end
        default:
          state <= S_RUN;
      endcase
    end
  end
endmodule // drs_reset_seq

// ---- verif/drs_seq_assertions.sv ----
// Purpose: port timing checks on the reset sequencer
// Assumes: full reject threshold, other counts shortened 4/50/100/30
// Notes:   rel_cnt counts from the last rising edge of the pin
`timescale 1ns/1ns
module drs_seq_chk #(
  parameter integer REJECT_CYC = 625,
  parameter integer ACCEPT_CYC = 1125,
  parameter integer SLEEP_CYC = 50,
  parameter integer AWAKE_CYC = 100
)(
  input wire core_clk,
  input wire rst,
  input wire hw_reset_line_n,
  input wire sleep_state,
  input wire core_reset,
  input wire display_blank,
  input wire release_busy,
  input wire load_busy,
  input wire sleep_default
);
  reg [23:0] rel_cnt;
  reg [15:0] low_run;
  reg        was_sleep;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // state kept from before the reset, since sleep_state may move during it
  always @(posedge core_clk)
  begin
    rel_cnt <= !hw_reset_line_n ? 24'h00_0000 : ((&rel_cnt) ? rel_cnt : rel_cnt + 24'h00_0001);
    low_run <= hw_reset_line_n ? 16'h0000 : ((&low_run) ? low_run : low_run + 16'h0001);
    if (!core_reset)
      was_sleep <= sleep_state;
  end
  blank_span_a: assert property (display_blank == core_reset) else $error("blank span differs");
  busy_span_a: assert property (release_busy == core_reset) else $error("busy span differs");
  spike_reject_a: assert property ($rose(core_reset) |-> low_run >= REJECT_CYC) else $error("reset on short pulse");
  long_accept_a: assert property (low_run >= ACCEPT_CYC |-> core_reset) else $error("long pulse not taken");
  glitch_ride_a: assert property ($rose(load_busy) |-> $past(hw_reset_line_n, 2) && $past(hw_reset_line_n, 5))
    else $error("load after spike");
  load_start_a: assert property ($rose(hw_reset_line_n) ##1 hw_reset_line_n [*5] ##0 core_reset |-> ##[0:50] load_busy)
    else $error("load late");
  load_inside_a: assert property ($rose(load_busy) |-> core_reset throughout (##[1:8] $fell(load_busy)))
    else $error("load overruns");
  rel_bound_a: assert property ($fell(core_reset) |-> rel_cnt <= (was_sleep ? SLEEP_CYC : AWAKE_CYC))
    else $error("release too long");
  end_dflt_a: assert property ($fell(core_reset) |-> sleep_default && !load_busy) else $error("no default");
endmodule // drs_seq_chk
bind drs_reset_seq drs_seq_chk #(.REJECT_CYC(REJECT_CYC), .SLEEP_CYC(SLEEP_CYC), .AWAKE_CYC(AWAKE_CYC))
  drs_seq_chk_inst (
  .core_clk(core_clk), .rst(rst), .hw_reset_line_n(hw_reset_line_n), .sleep_state(sleep_state),
  .core_reset(core_reset), .display_blank(display_blank), .release_busy(release_busy),
  .load_busy(load_busy), .sleep_default(sleep_default));

// ---- verif/drs_host_model.sv ----
// Purpose: host driving the display reset pin
// Assumes: pin changed just after rising edges
// Notes:   command side not modelled, so it stays idle
`timescale 1ns/1ns
module drs_host_model (
  input  wire core_clk,
  output reg  hw_reset_line_n
);
  initial hw_reset_line_n = 1'b1;
  // low pulse hold, two-cycle spike at spike_at
  task pulse(input integer len, input integer spike_at);
    integer i;
    begin
      for (i = 0; i < len; i = i + 1)
      begin
        @(posedge core_clk);
        hw_reset_line_n <= (i == spike_at) || (i == spike_at + 1);
      end
      @(posedge core_clk);
      hw_reset_line_n <= 1'b1;
    end
  endtask
  task settle(input integer cycles);
    repeat (cycles) @(posedge core_clk);
  endtask
endmodule // drs_host_model

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the reset sequencer
// Assumes: full reject threshold, other counts shortened 4/50/100/30
// Notes:   storage image left at its default contents
`timescale 1ns/1ns
module tb;
  reg        core_clk = 1'b0;
  reg        rst = 1'b1;
  reg        sleep_state = 1'b0;
  wire       hw_reset_line_n, core_reset, display_blank, release_busy, load_busy, sleep_default;
  wire [7:0] id_byte0, id_byte1, id_byte2, common_electrode_level;
  integer    n_mismatch = 0;
  integer    n_checks = 0;
  integer    n;
  integer    n_load;
  initial forever #4 core_clk = ~core_clk;
  drs_host_model drs_host_model_inst (.core_clk(core_clk), .hw_reset_line_n(hw_reset_line_n));
  drs_reset_seq #(.GLITCH_CYC(4), .SLEEP_CYC(50), .AWAKE_CYC(100), .BLANK_CYC(30))
  drs_reset_seq_inst (.core_clk(core_clk), .rst(rst), .hw_reset_line_n(hw_reset_line_n),
    .sleep_state(sleep_state), .core_reset(core_reset), .display_blank(display_blank),
    .release_busy(release_busy), .load_busy(load_busy), .id_byte0(id_byte0), .id_byte1(id_byte1),
    .id_byte2(id_byte2), .common_electrode_level(common_electrode_level), .sleep_default(sleep_default));
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // cycles from pin release to core release; a hang ends the run
  task wait_done;
    begin
      n = 0;
      n_load = 0;
      while (core_reset !== 1'b0 && n < 400)
      begin
        @(posedge core_clk);
        #1;
        n = n + 1;
        if (load_busy === 1'b1)
          n_load = n_load + 1;
      end
      if (n >= 400)
      begin
        n_mismatch = n_mismatch + 1;
        test_done;
      end
    end
  endtask
  task t_spike;
    begin
      // just under 5 us of low, must be rejected
      drs_host_model_inst.pulse(620, -9);
      repeat (20) @(posedge core_clk);
      check({7'h00, core_reset}, 8'h00);
    end
  endtask
  // awake reset of over 10 us with a short high spike inside
  task t_awake;
    begin
      drs_host_model_inst.pulse(1260, 700);
      #1;
      check({7'h00, core_reset}, 8'h01);
      check({7'h00, release_busy}, 8'h01);
      wait_done;
      check({7'h00, n <= 100}, 8'h01);
      check({7'h00, n_load > 0}, 8'h01);
      check(id_byte0, 8'h5a);
      check(id_byte1, 8'h3c);
      check(id_byte2, 8'h01);
      check(common_electrode_level, 8'h20);
      check({7'h00, sleep_default}, 8'h01);
      drs_host_model_inst.settle(100);
    end
  endtask
  task t_sleep;
    begin
      @(posedge core_clk) sleep_state <= 1'b1;
      drs_host_model_inst.pulse(1260, -9);
      #1;
      check({7'h00, display_blank}, 8'h01);
      wait_done;
      check({7'h00, n <= 50}, 8'h01);
      check({7'h00, n_load > 0}, 8'h01);
      check(id_byte0, 8'h5a);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(id_byte0, 8'h00);
    t_spike;
    t_awake;
    t_sleep;
    test_done;
  end
endmodule // tb
